// ===== hw/lcd_glass_defines.vh
// Function
// - the bias bit of the display control register picks half bias when 0 and one-third bias when 1.
// - duty code 00 gives 1/2 duty, 01 gives 1/3 duty, and any code with the upper bit set gives 1/4 duty.
// - with the enable bit clear the display is off and every backplane and frontplane line sits at ground.
// - the waveform bit picks the A-type drive waveform when 0 and the B-type waveform when 1.
// - at 1/2 duty rate codes 00..11 make each backplane phase 256, 280, 304 or 232 sub-oscillator ticks.
// - at 1/3 duty rate codes 00..11 make each backplane phase 172, 188, 204 or 156 sub-oscillator ticks.
// - at 1/4 duty rate codes 00..11 make each backplane phase 128, 140, 152 or 116 sub-oscillator ticks.
// - the five-bit RAM pointer picks one frontplane line, address 00H for line 0 up to 1FH for line 31.
// - the upper three bits of the RAM pointer register always read as zero.
// - the four-bit data window moves the addressed RAM entry, with data bit n belonging to backplane n.
`ifndef LCD_GLASS_DEFINES_VH
`define LCD_GLASS_DEFINES_VH

// ****************************************
// register indices and byte addresses
// ****************************************
`define IDX_DISPLAY_CONTROL 8'h09
`define IDX_DISPLAY_RAM_POINTER 8'h0A
`define IDX_DISPLAY_RAM_WINDOW 8'h0B
`define IDX_DISPLAY_STATUS 8'h10
`define ADDR_DISPLAY_CONTROL 8'h24
`define ADDR_DISPLAY_RAM_POINTER 8'h28
`define ADDR_DISPLAY_RAM_WINDOW 8'h2C
`define ADDR_DISPLAY_STATUS 8'h40

// ****************************************
// display control fields
// ****************************************
`define BIAS_CHOICE_BIT 7
`define DUTY_CHOICE_HI_BIT 6
`define DUTY_CHOICE_LO_BIT 5
`define DISPLAY_ENABLE_BIT 4
`define WAVEFORM_KIND_BIT 2
`define FRAME_RATE_HI_BIT 1
`define FRAME_RATE_LO_BIT 0
`define CONTROL_WRITE_MASK 8'hF7
`define CONTROL_RESET 8'h00
`define POINTER_RESET 5'h00

// ****************************************
// ticks of the sub-oscillator per backplane phase
// ****************************************
`define DIV_HALF_R0 9'h100
`define DIV_HALF_R1 9'h118
`define DIV_HALF_R2 9'h130
`define DIV_HALF_R3 9'h0E8
`define DIV_THIRD_R0 9'h0AC
`define DIV_THIRD_R1 9'h0BC
`define DIV_THIRD_R2 9'h0CC
`define DIV_THIRD_R3 9'h09C
`define DIV_QUARTER_R0 9'h080
`define DIV_QUARTER_R1 9'h08C
`define DIV_QUARTER_R2 9'h098
`define DIV_QUARTER_R3 9'h074

// ****************************************
// drive level codes
// ****************************************
`define LVL_GND 2'h0
`define LVL_LOW 2'h1
`define LVL_HIGH 2'h2
`define LVL_FULL 2'h3

`endif

// ===== hw/lcd_sync_edge.v
`timescale 1ns/1ps
`default_nettype none
module lcd_sync_edge (
  // clock and reset
  input wire mclk,
  input wire reset,
  // asynchronous level in, rising edge out
  input wire async_in,
  output wire rise
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = sync_q & ~prev_q;
endmodule // lcd_sync_edge
`default_nettype wire

// ===== hw/lcd_frame_timer.v
`timescale 1ns/1ps
`default_nettype none
module lcd_frame_timer #(
  parameter CW = 9
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // control
  input wire run,
  input wire tick,
  input wire [CW-1:0] divisor,
  // phase timing
  output wire phase_end,
  output wire second_half
);
  reg [CW-1:0] count_q;
  wire [CW-1:0] last;

  assign last = divisor - {{(CW-1){1'b0}}, 1'b1};
  // a divisor shortened below the count mid-phase ends the phase at the next tick
  assign phase_end = run & tick & (count_q >= last);
  assign second_half = count_q >= {1'b0, divisor[CW-1:1]};

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      count_q <= {CW{1'b0}};
    end else if (!run) begin
      count_q <= {CW{1'b0}};
    end else if (phase_end) begin
      count_q <= {CW{1'b0}};
    end else if (tick) begin
      count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule // lcd_frame_timer
`default_nettype wire

// ===== hw/lcd_glass_driver.v
`timescale 1ns/1ps
`default_nettype none
`include "lcd_glass_defines.vh"
module lcd_glass_driver #(
  parameter ADDR_W = 8,
  parameter LINES = 32
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // frame time base
  input wire sub_oscillator_clock,
  // glass drive, two-bit level code per line
  output reg [7:0] backplane_level_q,
  output reg [2*LINES-1:0] frontplane_level_q,
  output reg bias_third_q
);

  // ****************************************
  // functions
  // ****************************************
  function [8:0] phase_divisor;
    input [1:0] duty;
    input [1:0] rate;
    begin
      if (duty[1]) begin
        case (rate)
          2'h0: phase_divisor = `DIV_QUARTER_R0;
          2'h1: phase_divisor = `DIV_QUARTER_R1;
          2'h2: phase_divisor = `DIV_QUARTER_R2;
          default: phase_divisor = `DIV_QUARTER_R3;
        endcase
      end else if (duty[0]) begin
        case (rate)
          2'h0: phase_divisor = `DIV_THIRD_R0;
          2'h1: phase_divisor = `DIV_THIRD_R1;
          2'h2: phase_divisor = `DIV_THIRD_R2;
          default: phase_divisor = `DIV_THIRD_R3;
        endcase
      end else begin
        case (rate)
          2'h0: phase_divisor = `DIV_HALF_R0;
          2'h1: phase_divisor = `DIV_HALF_R1;
          2'h2: phase_divisor = `DIV_HALF_R2;
          default: phase_divisor = `DIV_HALF_R3;
        endcase
      end
    end
  endfunction

  // index of the last backplane scanned for a duty code
  function [1:0] last_backplane;
    input [1:0] duty;
    begin
      if (duty[1]) begin
        last_backplane = 2'h3;
      end else if (duty[0]) begin
        last_backplane = 2'h2;
      end else begin
        last_backplane = 2'h1;
      end
    end
  endfunction

  // level for one line; negative swaps the polarity of the cell voltage
  function [1:0] drive_level;
    input is_backplane;
    input selected;
    input negative;
    input third;
    begin
      if (is_backplane) begin
        if (selected) begin
          drive_level = negative ? `LVL_GND : `LVL_FULL;
        end else if (third) begin
          drive_level = negative ? `LVL_HIGH : `LVL_LOW;
        end else begin
          drive_level = `LVL_LOW;
        end
      end else begin
        if (selected) begin
          drive_level = negative ? `LVL_FULL : `LVL_GND;
        end else if (third) begin
          drive_level = negative ? `LVL_LOW : `LVL_HIGH;
        end else begin
          drive_level = negative ? `LVL_GND : `LVL_FULL;
        end
      end
    end
  endfunction

  // ****************************************
  // registers and storage
  // ****************************************
  reg [7:0] control_q;
  reg [4:0] pointer_q;
  reg [3:0] ram_q [0:LINES-1];
  reg [1:0] com_idx_q;
  reg frame_odd_q;
  integer i;

  wire bias_choice;
  wire [1:0] duty_choice;
  wire display_enable;
  wire waveform_kind;
  wire [1:0] frame_rate;
  wire [1:0] last_com;
  wire [8:0] divisor;
  wire sub_tick;
  wire phase_end;
  wire second_half;
  wire negative;

  assign bias_choice = control_q[`BIAS_CHOICE_BIT];
  assign duty_choice = {control_q[`DUTY_CHOICE_HI_BIT], control_q[`DUTY_CHOICE_LO_BIT]};
  assign display_enable = control_q[`DISPLAY_ENABLE_BIT];
  assign waveform_kind = control_q[`WAVEFORM_KIND_BIT];
  assign frame_rate = {control_q[`FRAME_RATE_HI_BIT], control_q[`FRAME_RATE_LO_BIT]};
  assign last_com = last_backplane(duty_choice);
  assign divisor = phase_divisor(duty_choice, frame_rate);

  // ****************************************
  // apb slave
  // ****************************************
  wire setup;
  wire access_done;
  wire wr_control;
  wire wr_pointer;
  wire wr_window;
  reg [31:0] read_mux;
  reg mapped;
  // read views; unused upper bits read as zero
  wire [31:0] control_word;
  wire [31:0] pointer_word;
  wire [31:0] window_word;
  wire [31:0] status_word;

  assign setup = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_control = access_done & pwrite & (paddr == `ADDR_DISPLAY_CONTROL);
  assign wr_pointer = access_done & pwrite & (paddr == `ADDR_DISPLAY_RAM_POINTER);
  assign wr_window = access_done & pwrite & (paddr == `ADDR_DISPLAY_RAM_WINDOW);
  assign control_word = {24'h000000, control_q};
  assign pointer_word = {27'h0000000, pointer_q};
  assign window_word = {28'h0000000, ram_q[pointer_q]};
  assign status_word = {28'h0000000, display_enable, com_idx_q, frame_odd_q};

  always @* begin
    read_mux = 32'h00000000;
    mapped = 1'b1;
    case (paddr)
      `ADDR_DISPLAY_CONTROL: begin
        read_mux = control_word;
      end
      `ADDR_DISPLAY_RAM_POINTER: begin
        read_mux = pointer_word;
      end
      `ADDR_DISPLAY_RAM_WINDOW: begin
        read_mux = window_word;
      end
      `ADDR_DISPLAY_STATUS: begin
        read_mux = status_word;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // no wait state: answer during the first access cycle
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : read_mux;
      end
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      control_q <= `CONTROL_RESET;
      pointer_q <= `POINTER_RESET;
    end else begin
      if (wr_control) begin
        control_q <= pwdata[7:0] & `CONTROL_WRITE_MASK;
      end
      if (wr_pointer) begin
        pointer_q <= pwdata[4:0];
      end
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < LINES; i = i + 1) begin
        ram_q[i] <= 4'h0;
      end
    end else if (wr_window) begin
      ram_q[pointer_q] <= pwdata[3:0];
    end
  end

  // ****************************************
  // frame timing
  // ****************************************
  lcd_sync_edge u_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in(sub_oscillator_clock),
    .rise(sub_tick)
  );

  lcd_frame_timer #(
    .CW(9)
  ) u_timer (
    .mclk(mclk),
    .reset(reset),
    .run(display_enable),
    .tick(sub_tick),
    .divisor(divisor),
    .phase_end(phase_end),
    .second_half(second_half)
  );

  // ****************************************
  // backplane scan
  // ****************************************
  // a duty change wraps a scan index past the new last
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      com_idx_q <= 2'h0;
      frame_odd_q <= 1'b0;
    end else if (!display_enable) begin
      com_idx_q <= 2'h0;
      frame_odd_q <= 1'b0;
    end else if (phase_end) begin
      if (com_idx_q >= last_com) begin
        com_idx_q <= 2'h0;
        frame_odd_q <= ~frame_odd_q;
      end else begin
        com_idx_q <= com_idx_q + 2'h1;
      end
    end
  end

  // a-type inverts inside each phase, b-type on alternate frames
  assign negative = waveform_kind ? frame_odd_q : second_half;

  // ****************************************
  // drive levels
  // ****************************************
  reg [7:0] bp_d;
  reg [2*LINES-1:0] fp_d;
  reg [3:0] entry;
  integer k;

  always @* begin
    bp_d = 8'h00;
    fp_d = {(2*LINES){1'b0}};
    entry = 4'h0;
    if (display_enable) begin
      for (k = 0; k < 4; k = k + 1) begin
        bp_d[2*k +: 2] = drive_level(1'b1, (k == com_idx_q) && (k <= last_com),
                                     negative, bias_choice);
      end
      for (k = 0; k < LINES; k = k + 1) begin
        entry = ram_q[k];
        fp_d[2*k +: 2] = drive_level(1'b0, entry[com_idx_q], negative,
                                     bias_choice);
      end
    end
  end

  // ****************************************
  // glass outputs
  // ****************************************

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      backplane_level_q <= 8'h00;
      frontplane_level_q <= {(2*LINES){1'b0}};
      bias_third_q <= 1'b0;
    end else begin
      backplane_level_q <= bp_d;
      frontplane_level_q <= fp_d;
      bias_third_q <= bias_choice;
    end
  end

endmodule // lcd_glass_driver
`default_nettype wire

// ===== test/lcd_glass_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_glass_checker #(
  parameter ADDR_W = 8,
  parameter LINES = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // glass
  input wire logic [7:0] backplane_level_q,
  input wire logic [2*LINES-1:0] frontplane_level_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire setup = psel && !penable;
  wire mapped = paddr inside {8'h24, 8'h28, 8'h2C, 8'h40};
  wire rd = pready && !pwrite;
  a_ready_after_setup: assert property (setup |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (setup && !mapped |=> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_ctrl_read_bits: assert property (rd && paddr == 8'h24 |-> prdata[31:8] == 0 && !prdata[3])
    else $error("control read has stray bits");
  a_ptr_upper_zero: assert property (rd && paddr == 8'h28 |-> prdata[31:5] == 0)
    else $error("pointer upper bits not zero");
  a_win_upper_zero: assert property (rd && paddr == 8'h2C |-> prdata[31:4] == 0)
    else $error("window upper bits not zero");
  a_off_ground: assert property (pready && pwrite && paddr == 8'h24 && !pwdata[4] |=> ##1
      (backplane_level_q == 0 && frontplane_level_q == 0)[*2])
    else $error("lines not grounded when off");
endmodule // lcd_glass_checker
bind lcd_glass_driver lcd_glass_checker #(.ADDR_W(ADDR_W), .LINES(LINES)) chk (
  .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .backplane_level_q(backplane_level_q), .frontplane_level_q(frontplane_level_q));
`default_nettype wire

// ===== test/glass_model.sv
`timescale 1ns/1ps
`default_nettype none
module glass_model (
  // clock and housekeeping
  input wire logic mclk,
  input wire logic clr,
  // backplane levels
  input wire logic [7:0] bp,
  // scan observations
  output var logic [1:0] sel_idx,
  output var logic [1:0] max_idx,
  output var int phase_len,
  output var int flips
);
  int cnt = 0;
  int fcnt = 0;
  logic [1:0] idx;
  logic [1:0] lvl;
  logic [1:0] lvl_q = 2'h0;
  // level of the selected backplane, to count polarity swaps inside a phase
  assign lvl = bp[2*idx +: 2];
  // the selected backplane sits at an outer level, the rest at an inner one
  always_comb begin
    idx = 2'h0;
    for (int n = 0; n < 4; n++)
      if (bp[2*n +: 2] == 2'h0 || bp[2*n +: 2] == 2'h3) idx = n[1:0];
  end
  always @(posedge mclk) begin
    cnt <= (idx != sel_idx) ? 1 : cnt + 1;
    if (idx != sel_idx) phase_len <= cnt;
    if (idx != sel_idx) begin
      flips <= fcnt;
      fcnt <= 0;
    end else if (lvl != lvl_q) begin
      fcnt <= fcnt + 1;
    end
    lvl_q <= lvl;
    sel_idx <= idx;
    max_idx <= clr ? 2'h0 : (idx > max_idx ? idx : max_idx);
  end
endmodule // glass_model
`default_nettype wire

// ===== test/tb_lcd_glass_driver.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb_lcd_glass_driver;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, sub_clk = 0, clr = 0;
  logic [1:0] sc = 0, sel_idx, max_idx;
  logic [7:0] paddr = 0, bp, ctrl;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [63:0] fp;
  logic pready, pslverr, bias, err;
  int phase_len, flips, errors = 0, num_checks = 0;
  int div[3][4] = '{'{256, 280, 304, 232}, '{172, 188, 204, 156}, '{128, 140, 152, 116}};
  lcd_glass_driver uut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sub_oscillator_clock(sub_clk), .backplane_level_q(bp),
    .frontplane_level_q(fp), .bias_third_q(bias));
  glass_model glass (.mclk(mclk), .clr(clr), .bp(bp), .sel_idx(sel_idx),
    .max_idx(max_idx), .phase_len(phase_len), .flips(flips));
  initial forever #50 mclk = ~mclk;
  // time base of four clock periods
  always @(posedge mclk) begin
    sc <= sc + 2'h1;
    sub_clk <= sc[1];
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #9500000;
    errors++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 0;
    apb(0, 8'h24, 0);
    `CHK(rd, 32'h0)
    `CHK({bp, fp}, 72'h0)
    apb(1, 8'h28, 32'hFF);
    apb(0, 8'h28, 0);
    `CHK(rd, 32'h1F)
    for (int j = 0; j < 32; j++) begin
      apb(1, 8'h28, j);
      apb(1, 8'h2C, 32'hF0 | (j ^ 5));
    end
    for (int j = 31; j >= 0; j--) begin
      apb(1, 8'h28, j);
      apb(0, 8'h2C, 0);
      `CHK(rd, (j ^ 5) & 15)
    end
    apb(0, 8'h30, 0);
    `CHK({err, rd}, 33'h100000000)
    for (int d = 0; d < 4; d++)
      for (int r = 0; r < 4; r++) begin
        if (d == 3 && r != 3) continue;
        ctrl = {d[0], d[1:0], 1'b1, 1'b0, r[0], r[1:0]};
        apb(1, 8'h24, {24'h0, ctrl});
        apb(0, 8'h24, 0);
        `CHK(rd, {24'h0, ctrl})
        `CHK(bias, d[0])
        apb(0, 8'h40, 0);
        `CHK(rd[31:3], 29'h1)
        repeat (2) @(sel_idx);
        clr <= 1;
        @(sel_idx);
        clr <= 0;
        repeat (4) @(sel_idx);
        `CHK(phase_len, div[d[1] ? 2 : d][r] * 4)
        `CHK(max_idx, d[1] ? 2'h3 : (d == 1 ? 2'h2 : 2'h1))
        `CHK(flips, r[0] ? 0 : 1)
        @(negedge mclk);
        `CHK(fp[1:0] === ~bp[2*sel_idx +: 2], sel_idx[0] == 1'b0)
        if (d < 2) `CHK(bp[7:6] == 2'h1 || (d == 1 && bp[7:6] == 2'h2), 1'b1)
      end
    apb(1, 8'h24, 0);
    repeat (4) @(posedge mclk);
    `CHK({bp, fp}, 72'h0)
    apb(0, 8'h40, 0);
    `CHK(rd, 32'h0)
    tally_and_finish;
  end
endmodule // tb_lcd_glass_driver
`default_nettype wire
